// *** design/osc_ctrl.sv ***
// Oscillator control register low byte with the source fields, behind a classic Wishbone slave.
// Assumes configuration straps are stable at reset release; pin and oscillator inputs are asynchronous.
// Notes on behaviour
// - With monitor enabled, lock bit blocks switching.
// - With monitor disabled, selection never locks.
// - Bit 5 reports PLL locked.
// - Lock status zero during switch or non-PLL mode.
// - Bit 3 sets when clock failure detected.
// - Bit 1 enables 32 kHz secondary oscillator.
// - Bit 0 requests switch, reads 0 when done.
// - Bits 6, 4, 2 read zero, ignore writes.
// - Source fields load from configuration at reset.
// - Next at 10:8, current at 14:12, gated.
// - Switching disabled holds request bit at zero.
// - Equal sources clear request and abort.
// - Wait ten new-source cycles, then copy fields.
`timescale 1ns/1ps
module osc_ctrl #(
   parameter int PLL_SOURCE_MASK = 8'h0a
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Configuration straps, sampled at reset.
   input wire logic failsafe_switch_config,
   input wire logic switching_enabled_config,
   input wire logic [osc_ctrl_pkg::SOURCE_WIDTH-1:0] initial_source_config,
   // Oscillator and monitor status, asynchronous.
   input wire logic pll_lock_raw,
   input wire logic failsafe_clock_monitor_fail,
   input wire logic new_src_clk_raw,
   // Oscillator control outputs.
   output logic secondary_osc_enable,
   output logic [osc_ctrl_pkg::SOURCE_WIDTH-1:0] active_source
);
   import osc_ctrl_pkg::*;

   initial begin
      if (PLL_SOURCE_MASK < 0 || PLL_SOURCE_MASK > 255) begin
         $error("PLL_SOURCE_MASK must fit one bit per source");
      end
   end

   osc_switch_if sw ();

   // Two-flop synchronisers; the first stage feeds only the second.
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic tick_prev_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         tick_prev_q <= 1'b0;
      end else begin
         sync1_q <= {new_src_clk_raw, failsafe_clock_monitor_fail, pll_lock_raw};
         sync2_q <= sync1_q;
         tick_prev_q <= sync2_q[2];
      end
   end
   logic pll_lock_s;
   logic fail_s;
   logic new_src_tick;
   assign pll_lock_s = sync2_q[0];
   assign fail_s = sync2_q[1];
   assign new_src_tick = sync2_q[2] & ~tick_prev_q;

   function automatic logic uses_pll(input source_t src);
      logic [7:0] mask;
      mask = PLL_SOURCE_MASK[7:0];
      return mask[src];
   endfunction

   // Straps are caught on the first clock after reset release.
   logic strap_taken_q;
   logic fsm_en_q;
   logic switch_en_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         strap_taken_q <= 1'b0;
         fsm_en_q <= 1'b0;
         switch_en_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         fsm_en_q <= failsafe_switch_config;
         switch_en_q <= switching_enabled_config;
      end
   end

   // Register state.
   logic clock_selection_lock_q;
   logic clock_fail_flag_q;
   logic secondary_osc_enable_q;
   logic switch_request_q;
   source_t next_source_field_q;
   source_t current_source_field_q;
   logic pll_lock_q;
   logic start_q;

   logic wr_ctl;
   logic req;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctl = req & wb_we_i & (wb_adr_i == ADDR_OSC_CONTROL);

   logic selection_locked;
   assign selection_locked = fsm_en_q & clock_selection_lock_q;

   // Source fields and the lock bit, which any low-byte write sets or clears.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         clock_selection_lock_q <= 1'b0;
         next_source_field_q <= '0;
         current_source_field_q <= '0;
      end else if (!strap_taken_q) begin
         next_source_field_q <= initial_source_config;
         current_source_field_q <= initial_source_config;
      end else begin
         if (wr_ctl && wb_sel_i[0]) begin
            clock_selection_lock_q <= wb_dat_i[BIT_CLOCK_SELECTION_LOCK];
         end
         if (wr_ctl && wb_sel_i[1] && !selection_locked && !sw.busy && !switch_request_q) begin
            next_source_field_q <= wb_dat_i[NEXT_SOURCE_LSB +: SOURCE_WIDTH];
         end
         if (sw.done) begin
            current_source_field_q <= next_source_field_q;
         end
      end
   end

   // Switch request bit and sequencer start.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         switch_request_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (!switch_en_q) begin
            switch_request_q <= 1'b0;
         end else if (sw.done) begin
            switch_request_q <= 1'b0;
         end else if (switch_request_q && !sw.busy && !start_q) begin
            if (next_source_field_q == current_source_field_q) begin
               switch_request_q <= 1'b0;
            end else begin
               start_q <= 1'b1;
            end
         end else if (wr_ctl && wb_sel_i[0] && wb_dat_i[BIT_SWITCH_REQUEST] && !selection_locked) begin
            switch_request_q <= 1'b1;
         end
      end
   end

   assign sw.start = start_q;
   assign sw.target = next_source_field_q;
   assign sw.target_uses_pll = uses_pll(next_source_field_q);

   // Secondary oscillator enable and failure flag; a new failure wins over a clear.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         secondary_osc_enable_q <= 1'b0;
         clock_fail_flag_q <= 1'b0;
      end else begin
         if (wr_ctl && wb_sel_i[0]) begin
            secondary_osc_enable_q <= wb_dat_i[BIT_SECONDARY_OSC_ENABLE];
         end
         if (fail_s) begin
            clock_fail_flag_q <= 1'b1;
         end else if (start_q) begin
            clock_fail_flag_q <= 1'b0;
         end else if (wr_ctl && wb_sel_i[0] && !wb_dat_i[BIT_CLOCK_FAIL_FLAG]) begin
            clock_fail_flag_q <= 1'b0;
         end
      end
   end

   // PLL lock status is held low through a switch and in any non-PLL mode.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pll_lock_q <= 1'b0;
      end else begin
         pll_lock_q <= pll_lock_s && !sw.busy && !start_q && uses_pll(current_source_field_q);
      end
   end

   logic [15:0] ctl_word;
   always_comb begin
      ctl_word = 16'h0000;
      ctl_word[BIT_CLOCK_SELECTION_LOCK] = clock_selection_lock_q;
      ctl_word[BIT_PLL_LOCK] = pll_lock_q;
      ctl_word[BIT_CLOCK_FAIL_FLAG] = clock_fail_flag_q;
      ctl_word[BIT_SECONDARY_OSC_ENABLE] = secondary_osc_enable_q;
      ctl_word[BIT_SWITCH_REQUEST] = switch_request_q;
      ctl_word[NEXT_SOURCE_LSB +: SOURCE_WIDTH] = next_source_field_q;
      ctl_word[CURRENT_SOURCE_LSB +: SOURCE_WIDTH] = current_source_field_q;
   end

   // Bus answer one cycle after the request; unmapped addresses read zero.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               ADDR_OSC_CONTROL: wb_dat_o <= {16'h0000, ctl_word};
               ADDR_OSC_STATUS: wb_dat_o <= {29'h0, switch_en_q, fsm_en_q, sw.busy};
               default: wb_dat_o <= UNMAPPED_READ;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         secondary_osc_enable <= 1'b0;
         active_source <= '0;
      end else begin
         secondary_osc_enable <= secondary_osc_enable_q;
         active_source <= current_source_field_q;
      end
   end

   osc_switch_seq u_seq (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .sw(sw.seq),
      .pll_locked(pll_lock_s),
      .new_src_tick(new_src_tick)
   );
endmodule // osc_ctrl

// *** design/osc_ctrl_pkg.sv ***
// Package for the oscillator control block: register offsets, field positions, the settle count and the state encoding.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package osc_ctrl_pkg;
   localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_OSC_STATUS = 8'h04;
   localparam int BIT_SWITCH_REQUEST = 0;
   localparam int BIT_SECONDARY_OSC_ENABLE = 1;
   localparam int BIT_CLOCK_FAIL_FLAG = 3;
   localparam int BIT_PLL_LOCK = 5;
   localparam int BIT_CLOCK_SELECTION_LOCK = 7;
   localparam int NEXT_SOURCE_LSB = 8;
   localparam int CURRENT_SOURCE_LSB = 12;
   localparam int SOURCE_WIDTH = 3;
   localparam logic [3:0] SETTLE_CYCLES = 4'ha;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
   typedef logic [SOURCE_WIDTH-1:0] source_t;
   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_WAIT_LOCK = 2'b01,
      SW_SETTLE = 2'b10
   } switch_state_e;
endpackage

// *** design/osc_switch_if.sv ***
// Interface carrying a switch request and its completion between the control top and the sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface osc_switch_if;
   import osc_ctrl_pkg::*;
   logic start;
   source_t target;
   logic target_uses_pll;
   logic done;
   logic busy;
   modport ctrl (output start, output target, output target_uses_pll, input done, input busy);
   modport seq (input start, input target, input target_uses_pll, output done, output busy);
endinterface

// *** design/osc_switch_seq.sv ***
// Clock switch sequencer: waits for PLL lock if needed, then counts settle edges of the new source.
// Assumes new_src_tick is already synchronised to the system clock.
`timescale 1ns/1ps
module osc_switch_seq (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Request from the control logic.
   osc_switch_if.seq sw,
   // Status from the oscillators.
   input wire logic pll_locked,
   input wire logic new_src_tick
);
   import osc_ctrl_pkg::*;
   switch_state_e state_q;
   logic [3:0] cnt_q;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_q <= SW_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (state_q)
            SW_IDLE: begin
               cnt_q <= 4'h0;
               if (sw.start) begin
                  state_q <= sw.target_uses_pll ? SW_WAIT_LOCK : SW_SETTLE;
               end
            end
            SW_WAIT_LOCK: begin
               if (pll_locked) begin
                  state_q <= SW_SETTLE;
               end
            end
            SW_SETTLE: begin
               // Edges of the new source are counted; the switch happens after the tenth.
               if (new_src_tick) begin
                  if (cnt_q == SETTLE_CYCLES - 4'h1) begin
                     state_q <= SW_IDLE;
                  end
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            default: state_q <= SW_IDLE;
         endcase
      end
   end

   assign sw.busy = (state_q != SW_IDLE);
   assign sw.done = (state_q == SW_SETTLE) && new_src_tick && (cnt_q == SETTLE_CYCLES - 4'h1);
endmodule // osc_switch_seq

// *** testbench/osc_ctrl_assertions.sv ***
// Checker for the oscillator control block, bound to its top module.
// Assumes the bench master keeps to single classic Wishbone cycles.
`timescale 1ns/1ps
module osc_ctrl_assertions #(
   parameter int PLL_SOURCE_MASK = 8'h0a
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Bus.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Straps and outputs.
   input wire logic switching_enabled_config,
   input wire logic secondary_osc_enable,
   input wire logic [osc_ctrl_pkg::SOURCE_WIDTH-1:0] active_source
);
   import osc_ctrl_pkg::*;
   logic rd0;
   assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == ADDR_OSC_CONTROL;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
   a_reserved_zero: assert property (rd0 |-> (wb_dat_o & 32'h00008854) == 32'h0)
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != ADDR_OSC_CONTROL
      && wb_adr_i != ADDR_OSC_STATUS |-> wb_dat_o == UNMAPPED_READ) else $error("unmapped read not zero");
   a_secondary_oscillator_follows: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADDR_OSC_CONTROL && wb_sel_i[0]
      |=> secondary_osc_enable == $past(wb_dat_i[1])) else $error("oscillator enable did not follow write");
   a_current_mirror: assert property (rd0 |-> wb_dat_o[14:12] == active_source)
      else $error("current field differs from active source");
   a_nonpll_unlocked: assert property (rd0 && !PLL_SOURCE_MASK[wb_dat_o[14:12]] |-> !wb_dat_o[5])
      else $error("lock status set in non-PLL mode");
   a_fixed_source: assert property (!switching_enabled_config && $past(rstn, 3) && $past(rstn, 2)
      && $past(rstn) |-> $stable(active_source)) else $error("source changed with switching disabled");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_fail_read: cover property (rd0 && wb_dat_o[3]);
   c_switch: cover property ($changed(active_source));
endmodule // osc_ctrl_assertions
bind osc_ctrl osc_ctrl_assertions #(.PLL_SOURCE_MASK(PLL_SOURCE_MASK)) chk (.ref_clk(ref_clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .switching_enabled_config(switching_enabled_config),
   .secondary_osc_enable(secondary_osc_enable), .active_source(active_source));

// *** testbench/oscillator_control_low_byte_bench.sv ***
// Self-checking bench for the oscillator control block over classic Wishbone.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/1ps
module oscillator_control_low_byte_bench;
   import osc_ctrl_pkg::*;
   logic ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fs, sw, pll, fail, nclk, secondary_oscillator;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [2:0] src, act;
   logic [1:0] div_q;
   int miscompares = 0;
   int checks_done = 0;
   osc_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .failsafe_switch_config(fs), .switching_enabled_config(sw), .initial_source_config(src),
      .pll_lock_raw(pll), .failsafe_clock_monitor_fail(fail), .new_src_clk_raw(nclk),
      .secondary_osc_enable(secondary_oscillator), .active_source(act));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // The new source runs at one sixth of the system clock, unrelated to bus timing.
   always @(posedge ref_clk) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) nclk <= ~nclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Values are read before the edge's updates land, which is the Wishbone sampling point.
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      // Only the watchdog ends a wait that never sees the answer.
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdchk(input string nm, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, ADDR_OSC_CONTROL, 4'hf, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic wl(input logic [7:0] v);
      logic [31:0] q;
      wb(1'b1, ADDR_OSC_CONTROL, 4'h1, {24'h0, v}, q);
   endtask
   task automatic req(input logic [2:0] s, input logic [7:0] v);
      logic [31:0] q;
      wb(1'b1, ADDR_OSC_CONTROL, 4'h2, {21'h0, s, 8'h0}, q);
      wl(v);
   endtask
   task automatic poll();
      logic [31:0] q;
      int n;
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 100) begin
         wb(1'b0, ADDR_OSC_CONTROL, 4'hf, 32'h0, q);
         n++;
      end
      chk("switch_done", 32'h0, {31'h0, q[0]});
   endtask
   task automatic do_reset(input logic f, input logic s, input logic [2:0] i);
      rstn <= 1'b0;
      fs <= f;
      sw <= s;
      src <= i;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   initial begin
      logic [31:0] q;
      {rstn, wb_cyc_i, wb_stb_i, wb_we_i, pll, fail, nclk, div_q} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, fs, sw, src} = '0;
      @(posedge ref_clk);
      do_reset(1'b1, 1'b1, 3'h2);
      rdchk("fields_at_reset", 32'h7700, 32'h2200);
      chk("active_source", 32'h2, {29'h0, act});
      wl(8'h56);
      rdchk("low_byte", 32'hff, 32'h02);
      chk("secondary_oscillator_on", 32'h1, {31'h0, secondary_oscillator});
      fail <= 1'b1;
      repeat (4) @(posedge ref_clk);
      fail <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdchk("fail_set", 32'h8, 32'h8);
      rdchk("fail_held", 32'h8, 32'h8);
      wl(8'h00);
      rdchk("fail_clear", 32'h8, 32'h0);
      chk("secondary_oscillator_off", 32'h0, {31'h0, secondary_oscillator});
      wl(8'h01);
      repeat (5) @(posedge ref_clk);
      rdchk("redundant", 32'h7001, 32'h2000);
      req(3'h3, 8'h01);
      repeat (100) @(posedge ref_clk);
      rdchk("wait_pll", 32'h7021, 32'h2001);
      pll <= 1'b1;
      poll();
      rdchk("pll_done", 32'h7020, 32'h3020);
      req(3'h4, 8'h01);
      poll();
      rdchk("nonpll_done", 32'h7020, 32'h4000);
      chk("active_new", 32'h4, {29'h0, act});
      wl(8'h80);
      req(3'h2, 8'h81);
      repeat (100) @(posedge ref_clk);
      rdchk("locked", 32'h7001, 32'h4000);
      wb(1'b0, 8'h08, 4'hf, 32'h0, q);
      chk("unmapped", 32'h0, q);
      do_reset(1'b0, 1'b1, 3'h4);
      wl(8'h80);
      req(3'h1, 8'h81);
      poll();
      rdchk("never_locked", 32'h7000, 32'h1000);
      do_reset(1'b1, 1'b0, 3'h5);
      req(3'h6, 8'h01);
      repeat (100) @(posedge ref_clk);
      rdchk("sw_disabled", 32'h7001, 32'h5000);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      close_out();
   end
endmodule // oscillator_control_low_byte_bench
